/* File: logic/extended_register_window.sv */
`timescale 1ns/100ps
`include "xreg_defs.svh"
module extended_register_window (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // power management and mode
  input wire logic seg_reset_in,
  input wire logic pme_enable_in,
  input wire logic pci_way_mode_in,
  // host register access
  input wire xreg_pkg::host_req_t host_req_in,
  output logic [7:0] host_rdata_out,
  // socket power control writes
  input wire logic [1:0] pwr_wr_in,
  input wire logic [1:0] pwr_vcc_in,
  output logic [1:0] vcc_power_out,
  // card side, per socket
  input wire xreg_pkg::card_pins_t [1:0] card_pins_in,
  output logic [1:0] pullup_off_out,
  output logic [1:0] card_present_out,
  output logic [1:0] card_event_out,
  output logic [1:0] dma_req_out,
  output logic [1:0] dma_enable_out,
  // window upper address compare
  input wire logic [7:0] pci_addr_hi_in,
  input wire logic [1:0][6:0] win_type_in,
  input wire logic [1:0][6:0] pci_space_in,
  output logic [1:0][6:0] upper_ok_out,
  // shared pin one sources
  input wire logic irq_a_n_in,
  input wire logic general_pin_one_in,
  input wire logic general_pin_one_oe_in,
  // shared pin two sources
  input wire logic serial_interrupt_data_in,
  input wire logic serial_interrupt_data_oe_in,
  input wire logic general_pin_two_in,
  input wire logic general_pin_two_oe_in,
  input wire logic pin2_in,
  // shared pin drive and indicators
  output logic pin1_o_out,
  output logic pin1_oe_out,
  output logic pin2_o_out,
  output logic pin2_oe_out,
  output logic serial_interrupt_in_out,
  output logic socket_a_indicator_n_out,
  output logic socket_b_indicator_n_out,
  output logic combined_activity_indicator_n_out
);

  logic [1:0][7:0] idx_r;
  logic [1:0][7:0] ctrl_r;
  logic [1:0][6:0][7:0] win_r;
  logic [7:0] pin_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_val;
  logic [1:0] ind_n;
  logic p1_o_r, p1_oe_r, p2_o_r, p2_oe_r, sin_r;
  logic p1_o_nxt, p1_oe_nxt, p2_o_nxt, p2_oe_nxt;
  xreg_pkg::pin_func_t pin1_fn, pin2_fn;

  // access decode: i/o index/data ports or memory offsets
  wire is_mem = host_req_in.is_mem;
  wire [7:0] port = host_req_in.addr[7:0];
  wire [11:0] moff = host_req_in.addr;
  wire io_ok = !is_mem && (host_req_in.addr[11:8] == 4'h0);
  wire port_b = (port == `XR_IO_IDX_B) || (port == `XR_IO_DAT_B);
  wire acc_sock = is_mem ? host_req_in.func : port_b;
  wire io_idx = io_ok && ((port == `XR_IO_IDX_A) || (port == `XR_IO_IDX_B));
  wire io_dat = io_ok && ((port == `XR_IO_DAT_A) || (port == `XR_IO_DAT_B));
  wire [7:0] key = idx_r[acc_sock];

  // target selection, by index for the data port, by offset for memory
  wire io_win_lo = (key >= `XR_IDX_WIN0) && (key <= `XR_IDX_WIN4);
  wire io_win_hi = (key == `XR_IDX_WIN5) || (key == `XR_IDX_WIN6);
  wire mem_win = (moff >= `XR_MEM_WIN0) && (moff <= `XR_MEM_WIN6);
  wire ctrl_hit = (io_dat && key == `XR_IDX_CTRL) || (is_mem && moff == `XR_MEM_CTRL);
  wire win_hit = (io_dat && (io_win_lo || io_win_hi)) || (is_mem && mem_win);
  wire pin_hit = (io_dat && key == `XR_IDX_PINMUX) ||
                 (is_mem && moff == `XR_MEM_PINMUX && !host_req_in.func);
  wire [2:0] io_win_n = io_win_lo ? 3'(key - `XR_IDX_WIN0) :
                        ((key == `XR_IDX_WIN5) ? 3'h5 : 3'h6);
  wire [2:0] win_n = is_mem ? 3'(moff - `XR_MEM_WIN0) : io_win_n;

  // write strobes
  wire wr_idx = host_req_in.wr && io_idx;
  wire wr_ctrl = host_req_in.wr && ctrl_hit;
  wire wr_win = host_req_in.wr && win_hit;
  wire wr_pin = host_req_in.wr && pin_hit;

  // pin mux keeps its value over a segment reset while pme is enabled
  wire pin_clear = seg_reset_in && !pme_enable_in;

  // read mux; anything unmapped answers zero
  assign rd_val = io_idx ? key :
                  ctrl_hit ? ctrl_r[acc_sock] :
                  win_hit ? win_r[acc_sock][win_n] :
                  pin_hit ? pin_r : `XR_NONE_RD;

  // per-socket index, control and window registers
  genvar s, w;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      wire sel = (acc_sock == 1'(s));

      // index register, full 8 bits stored
      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          idx_r[s] <= `XR_IDX_RST;
        end else if (seg_reset_in) begin
          idx_r[s] <= `XR_IDX_RST;
        end else if (wr_idx && sel) begin
          idx_r[s] <= host_req_in.wdata;
        end
      end

      // control register; reserved bits are kept but drive nothing
      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          ctrl_r[s] <= `XR_CTRL_RST;
        end else if (seg_reset_in) begin
          ctrl_r[s] <= `XR_CTRL_RST;
        end else if (wr_ctrl && sel) begin
          ctrl_r[s] <= host_req_in.wdata;
        end
      end

      for (w = 0; w < 7; w++) begin : g_win
        // upper address byte of one window
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
          if (!arst_n_in) begin
            win_r[s][w] <= `XR_WIN_RST;
          end else if (seg_reset_in) begin
            win_r[s][w] <= `XR_WIN_RST;
          end else if (wr_win && sel && win_n == 3'(w)) begin
            win_r[s][w] <= host_req_in.wdata;
          end
        end
      end

      socket_ext_ctrl u_ctrl (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .ctrl_in(ctrl_r[s]),
        .pci_way_mode_in(pci_way_mode_in),
        .pwr_wr_in(pwr_wr_in[s]),
        .pwr_vcc_in(pwr_vcc_in[s]),
        .vcc_power_out(vcc_power_out[s]),
        .pins_in(card_pins_in[s]),
        .indicator_n_out(ind_n[s]),
        .pullup_off_out(pullup_off_out[s]),
        .card_present_out(card_present_out[s]),
        .card_event_out(card_event_out[s]),
        .dma_req_out(dma_req_out[s]),
        .dma_enable_out(dma_enable_out[s])
      );

      window_upper_match u_match (
        .upper_in(win_r[s]),
        .type_sel_in(win_type_in[s]),
        .host_space_in(pci_space_in[s]),
        .addr_hi_in(pci_addr_hi_in),
        .use_upper_out(),
        .upper_ok_out(upper_ok_out[s])
      );
    end
  endgenerate

  // chip-wide pin multiplex register
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_r <= `XR_PIN_RST;
    end else if (pin_clear) begin
      pin_r <= `XR_PIN_RST;
    end else if (wr_pin) begin
      pin_r <= host_req_in.wdata;
    end
  end

  // read data held until the next read
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= `XR_NONE_RD;
    end else if (host_req_in.rd) begin
      rdata_r <= rd_val;
    end
  end
  assign host_rdata_out = rdata_r;

  // shared pin functions; codes 10 and 11 release the pin as a safe default
  assign pin1_fn = xreg_pkg::pin_func_t'(pin_r[`XR_PIN1_HI:`XR_PIN1_LO]);
  assign pin2_fn = xreg_pkg::pin_func_t'(pin_r[`XR_PIN2_HI:`XR_PIN2_LO]);

  // pin one: open-drain interrupt a or socket a indicator, or general pin
  always_comb begin
    p1_o_nxt = 1'b0;
    p1_oe_nxt = 1'b0;
    unique case (pin1_fn)
      xreg_pkg::PIN_NATIVE: p1_oe_nxt = pci_way_mode_in ? !ind_n[0] : !irq_a_n_in;
      xreg_pkg::PIN_GENERAL: begin
        p1_o_nxt = general_pin_one_in;
        p1_oe_nxt = general_pin_one_oe_in;
      end
      default: p1_oe_nxt = 1'b0;
    endcase
  end

  // pin two: serial interrupt or socket b indicator, or general pin
  always_comb begin
    p2_o_nxt = 1'b0;
    p2_oe_nxt = 1'b0;
    unique case (pin2_fn)
      xreg_pkg::PIN_NATIVE: begin
        p2_o_nxt = pci_way_mode_in ? 1'b0 : serial_interrupt_data_in;
        p2_oe_nxt = pci_way_mode_in ? !ind_n[1] : serial_interrupt_data_oe_in;
      end
      xreg_pkg::PIN_GENERAL: begin
        p2_o_nxt = general_pin_two_in;
        p2_oe_nxt = general_pin_two_oe_in;
      end
      default: p2_oe_nxt = 1'b0;
    endcase
  end

  // pin drive flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      p1_o_r <= 1'b0;
      p1_oe_r <= 1'b0;
      p2_o_r <= 1'b0;
      p2_oe_r <= 1'b0;
      sin_r <= 1'b1;
    end else begin
      p1_o_r <= p1_o_nxt;
      p1_oe_r <= p1_oe_nxt;
      p2_o_r <= p2_o_nxt;
      p2_oe_r <= p2_oe_nxt;
      sin_r <= (pin2_fn == xreg_pkg::PIN_NATIVE && !pci_way_mode_in) ? pin2_in : 1'b1;
    end
  end

  assign pin1_o_out = p1_o_r;
  assign pin1_oe_out = p1_oe_r;
  assign pin2_o_out = p2_o_r;
  assign pin2_oe_out = p2_oe_r;
  assign serial_interrupt_in_out = sin_r;
  assign socket_a_indicator_n_out = ind_n[0];
  assign socket_b_indicator_n_out = ind_n[1];
  assign combined_activity_indicator_n_out = &ind_n;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  index_write_a: assert property (wr_idx && !acc_sock && !seg_reset_in |=>
      idx_r[0] == $past(host_req_in.wdata))
    else $error("index write not stored");
  index_clear_a: assert property (seg_reset_in |=> idx_r == '0)
    else $error("index not cleared by segment reset");
  ctrl_read_a: assert property (host_req_in.rd && io_dat && !acc_sock && key == `XR_IDX_CTRL
      |=> host_rdata_out == $past(ctrl_r[0]))
    else $error("data port read wrong control value");
  win_write_a: assert property (wr_win && !seg_reset_in && acc_sock && win_n == 3'h6
      |=> win_r[1][6] == $past(host_req_in.wdata))
    else $error("window upper write lost");
  unmapped_zero_a: assert property (host_req_in.rd && io_dat && !ctrl_hit && !win_hit
      && !pin_hit |=> host_rdata_out == 8'h00)
    else $error("unmapped index read nonzero");
  pin_keep_a: assert property (seg_reset_in && pme_enable_in && !wr_pin |=> $stable(pin_r))
    else $error("pin mux lost over segment reset");
  func1_block_a: assert property (host_req_in.wr && is_mem && host_req_in.func
      && moff == `XR_MEM_PINMUX && !pin_clear |=> $stable(pin_r))
    else $error("pin mux written through function 1");
  win_cmp_a: assert property (!win_type_in[0][0] && win_r[0][0] != pci_addr_hi_in
      |-> !upper_ok_out[0][0])
    else $error("window 0 upper mismatch accepted");
  win_ignore_a: assert property (win_type_in[0][5] && pci_space_in[0][5]
      |-> upper_ok_out[0][5])
    else $error("ignored upper byte affected match");
  pin1_general_a: assert property (pin1_fn == xreg_pkg::PIN_GENERAL |=>
      pin1_o_out == $past(general_pin_one_in) && pin1_oe_out == $past(general_pin_one_oe_in))
    else $error("pin one not general function");

  // bus side: read data, index, clears and the function 0 copy
  rdata_hold_a: assert property (!host_req_in.rd |=> $stable(host_rdata_out))
    else $error("read data changed without a read");
  idx_read_a: assert property (host_req_in.rd && io_idx && !acc_sock
      |=> host_rdata_out == $past(idx_r[0]))
    else $error("index port read wrong value");
  pin_read_a: assert property (host_req_in.rd && pin_hit |=> host_rdata_out == $past(pin_r))
    else $error("pin mux read wrong value");
  seg_clear_a: assert property (seg_reset_in |=> ctrl_r == '0 && win_r == '0)
    else $error("control or window not cleared by segment reset");
  pin_clear_a: assert property (pin_clear |=> pin_r == 8'h00)
    else $error("pin mux kept over segment reset without pme");
  func0_write_a: assert property (host_req_in.wr && is_mem && !host_req_in.func
      && moff == `XR_MEM_PINMUX && !pin_clear |=> pin_r == $past(host_req_in.wdata))
    else $error("pin mux write through function 0 lost");

  // window and shared pin side
  win_host_a: assert property (win_type_in[0][6] && !pci_space_in[0][6]
      && win_r[0][6] != pci_addr_hi_in |-> !upper_ok_out[0][6])
    else $error("host-side window 6 upper mismatch accepted");
  pin1_native_a: assert property (pin1_fn == xreg_pkg::PIN_NATIVE && !pci_way_mode_in
      |=> pin1_oe_out == !$past(irq_a_n_in) && !pin1_o_out)
    else $error("pin one not driving interrupt a");
  pin2_native_a: assert property (pin2_fn == xreg_pkg::PIN_NATIVE && pci_way_mode_in
      |=> pin2_oe_out == !$past(ind_n[1]) && !pin2_o_out)
    else $error("pin two not showing socket b indicator");
  pin2_general_a: assert property (pin2_fn == xreg_pkg::PIN_GENERAL |=>
      pin2_o_out == $past(general_pin_two_in) && pin2_oe_out == $past(general_pin_two_oe_in))
    else $error("pin two not general function");
  pin1_bad_a: assert property (pin_r[`XR_PIN1_HI] |=> !pin1_oe_out && !pin1_o_out)
    else $error("pin one driven under an illegal code");
  pin2_bad_a: assert property (pin_r[`XR_PIN2_HI] |=> !pin2_oe_out && !pin2_o_out)
    else $error("pin two driven under an illegal code");
  sin_idle_a: assert property (pci_way_mode_in |=> serial_interrupt_in_out)
    else $error("serial interrupt input active in pci/way mode");

  ctrl_io_write_c: cover property (wr_ctrl && io_dat);
  pin_mem_write_c: cover property (wr_pin && is_mem);
  unmapped_read_c: cover property (host_req_in.rd && io_dat && !ctrl_hit && !win_hit && !pin_hit);
  keep_over_reset_c: cover property (seg_reset_in && pme_enable_in && pin_r != 8'h00);
  sock_b_io_c: cover property (wr_ctrl && io_dat && acc_sock);

endmodule // extended_register_window

/* File: logic/xreg_defs.svh */
`ifndef XREG_DEFS_SVH
`define XREG_DEFS_SVH

// i/o ports of the index/data pairs
`define XR_IO_IDX_A 8'h2E
`define XR_IO_DAT_A 8'h2F
`define XR_IO_IDX_B 8'h6E
`define XR_IO_DAT_B 8'h6F

// extended index values
`define XR_IDX_CTRL 8'h03
`define XR_IDX_WIN0 8'h05
`define XR_IDX_WIN4 8'h09
`define XR_IDX_PINMUX 8'h14
`define XR_IDX_WIN5 8'h20
`define XR_IDX_WIN6 8'h21

// memory offsets
`define XR_MEM_WIN0 12'h840
`define XR_MEM_WIN6 12'h846
`define XR_MEM_CTRL 12'h903
`define XR_MEM_PINMUX 12'h914

// socket control field positions
`define XR_CTRL_LOCK 0
`define XR_CTRL_LED 2
`define XR_CTRL_PULLUP 5
`define XR_CTRL_DREQ_LO 6
`define XR_CTRL_DREQ_HI 7

// pin multiplex field positions
`define XR_PIN1_LO 0
`define XR_PIN1_HI 1
`define XR_PIN2_LO 2
`define XR_PIN2_HI 3

// reset values
`define XR_IDX_RST 8'h00
`define XR_CTRL_RST 8'h00
`define XR_WIN_RST 8'h00
`define XR_PIN_RST 8'h00
`define XR_NONE_RD 8'h00

`endif

/* File: logic/xreg_pkg.sv */
package xreg_pkg;

  // card pin used as dma request
  typedef enum logic [1:0] {
    DREQ_OFF = 2'h0,
    DREQ_INPACK = 2'h1,
    DREQ_WP = 2'h2,
    DREQ_BVD2 = 2'h3
  } dreq_sel_t;

  // shared pin function codes
  typedef enum logic [1:0] {
    PIN_NATIVE = 2'h0,
    PIN_GENERAL = 2'h1,
    PIN_BAD2 = 2'h2,
    PIN_BAD3 = 2'h3
  } pin_func_t;

  // one host access, i/o port or memory offset
  typedef struct packed {
    logic rd;
    logic wr;
    logic is_mem;
    logic func;
    logic [11:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // card-side signals of one socket
  typedef struct packed {
    logic inpack_n;
    logic wp;
    logic bvd2;
    logic card_in;
    logic busy;
  } card_pins_t;

endpackage

/* File: logic/window_upper_match.sv */
`timescale 1ns/100ps
module window_upper_match (
  // window settings
  input wire logic [6:0][7:0] upper_in,
  input wire logic [6:0] type_sel_in,
  input wire logic [6:0] host_space_in,
  // address bits 31:24
  input wire logic [7:0] addr_hi_in,
  // per-window result
  output logic [6:0] use_upper_out,
  output logic [6:0] upper_ok_out
);

  // only windows 0..4 may be memory windows with type clear
  genvar w;
  generate
    for (w = 0; w < 7; w++) begin : g_win
      wire type_mem = (w <= 4) && !type_sel_in[w];
      wire host_mem = type_sel_in[w] && !host_space_in[w];
      assign use_upper_out[w] = type_mem || host_mem;
      assign upper_ok_out[w] = !use_upper_out[w] || (upper_in[w] == addr_hi_in);
    end
  endgenerate

endmodule // window_upper_match

/* File: logic/socket_ext_ctrl.sv */
`timescale 1ns/100ps
`include "xreg_defs.svh"
module socket_ext_ctrl (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // control register value and mode
  input wire logic [7:0] ctrl_in,
  input wire logic pci_way_mode_in,
  // power control write
  input wire logic pwr_wr_in,
  input wire logic pwr_vcc_in,
  output logic vcc_power_out,
  // card side
  input wire xreg_pkg::card_pins_t pins_in,
  output logic indicator_n_out,
  output logic pullup_off_out,
  output logic card_present_out,
  output logic card_event_out,
  output logic dma_req_out,
  output logic dma_enable_out
);

  logic vcc_r, vcc_nxt;
  logic ind_n_r, ind_n_nxt;
  logic present_r, present_nxt;
  logic pu_q_r;
  logic event_r, event_nxt;
  logic dreq_r, dreq_nxt;
  xreg_pkg::dreq_sel_t dreq_sel;

  // lock keeps card drivers from overriding socket power
  wire lock = ctrl_in[`XR_CTRL_LOCK];
  assign vcc_nxt = (pwr_wr_in && !lock) ? pwr_vcc_in : vcc_r;

  // indicator low while card cycles run, only in pci/way mode
  assign ind_n_nxt = !(ctrl_in[`XR_CTRL_LED] && pins_in.busy && pci_way_mode_in);

  // pull-ups off also disables the sense inputs, so presence freezes
  wire pullup_off = ctrl_in[`XR_CTRL_PULLUP];
  assign present_nxt = pullup_off ? present_r : pins_in.card_in;
  wire sense_change = !pullup_off && (pins_in.card_in != present_r);
  wire pu_rise = pullup_off && !pu_q_r && present_r;
  assign event_nxt = sense_change || pu_rise;

  // dma request source select
  assign dreq_sel = xreg_pkg::dreq_sel_t'(ctrl_in[`XR_CTRL_DREQ_HI:`XR_CTRL_DREQ_LO]);
  always_comb begin
    unique case (dreq_sel)
      xreg_pkg::DREQ_OFF: dreq_nxt = 1'b0;
      xreg_pkg::DREQ_INPACK: dreq_nxt = !pins_in.inpack_n;
      xreg_pkg::DREQ_WP: dreq_nxt = pins_in.wp;
      xreg_pkg::DREQ_BVD2: dreq_nxt = pins_in.bvd2;
    endcase
  end

  // state flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vcc_r <= 1'b0;
      ind_n_r <= 1'b1;
      present_r <= 1'b0;
      pu_q_r <= 1'b0;
      event_r <= 1'b0;
      dreq_r <= 1'b0;
    end else begin
      vcc_r <= vcc_nxt;
      ind_n_r <= ind_n_nxt;
      present_r <= present_nxt;
      pu_q_r <= pullup_off;
      event_r <= event_nxt;
      dreq_r <= dreq_nxt;
    end
  end

  assign vcc_power_out = vcc_r;
  assign indicator_n_out = ind_n_r;
  assign pullup_off_out = pullup_off;
  assign card_present_out = present_r;
  assign card_event_out = event_r;
  assign dma_req_out = dreq_r;
  assign dma_enable_out = (dreq_sel != xreg_pkg::DREQ_OFF);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  lock_hold_a: assert property (lock && pwr_wr_in |=> vcc_power_out == $past(vcc_power_out))
    else $error("locked vcc bit changed");
  led_low_a: assert property (ctrl_in[2] && pins_in.busy && pci_way_mode_in |=> !indicator_n_out)
    else $error("indicator not low during card cycle");
  led_mode_a: assert property (!pci_way_mode_in |=> indicator_n_out)
    else $error("indicator active outside pci/way mode");
  sense_freeze_a: assert property (pullup_off && pu_q_r |=> !card_event_out)
    else $error("card change seen with pull-ups off");
  pullup_event_a: assert property (pullup_off && !pu_q_r && present_r |=> card_event_out)
    else $error("no card detect event on pull-up shutoff");
  dreq_map_a: assert property (dreq_sel == xreg_pkg::DREQ_WP |=> dma_req_out == $past(pins_in.wp))
    else $error("dma request not taken from wp pin");
  dreq_off_a: assert property (dreq_sel == xreg_pkg::DREQ_OFF |=> !dma_req_out)
    else $error("dma request active while disabled");

endmodule // socket_ext_ctrl

/* File: test/extended_register_window_tb.sv */
`timescale 1ns/100ps
module extended_register_window_tb;
  // bench side of every design port but the two serial interrupt data inputs, which are tied off
  logic clk, arst_n, seg, pme, way, g1, g1_oe, g2, g2_oe, irq_n, pin2;
  xreg_pkg::host_req_t hr;
  logic [7:0] rdata, addr_hi;
  logic [1:0] pwr_wr, pwr_vcc, vcc, pu_off, present, event_o, dreq, den;
  xreg_pkg::card_pins_t [1:0] pins;
  logic [1:0][6:0] wtype, wspace, upper_ok;
  logic p1_o, p1_oe, p2_o, p2_oe, sin, ind_a_n, ind_b_n, ind_c_n;
  int num_errors, compares, ev_cnt;

  extended_register_window u_extended_register_window (
    .sys_clk_in(clk), .arst_n_in(arst_n), .seg_reset_in(seg), .pme_enable_in(pme),
    .pci_way_mode_in(way), .host_req_in(hr), .host_rdata_out(rdata),
    .pwr_wr_in(pwr_wr), .pwr_vcc_in(pwr_vcc), .vcc_power_out(vcc),
    .card_pins_in(pins), .pullup_off_out(pu_off), .card_present_out(present),
    .card_event_out(event_o), .dma_req_out(dreq), .dma_enable_out(den),
    .pci_addr_hi_in(addr_hi), .win_type_in(wtype), .pci_space_in(wspace),
    .upper_ok_out(upper_ok), .irq_a_n_in(irq_n), .general_pin_one_in(g1),
    .general_pin_one_oe_in(g1_oe), .serial_interrupt_data_in(1'b1),
    .serial_interrupt_data_oe_in(1'b0), .general_pin_two_in(g2),
    .general_pin_two_oe_in(g2_oe), .pin2_in(pin2), .pin1_o_out(p1_o),
    .pin1_oe_out(p1_oe), .pin2_o_out(p2_o), .pin2_oe_out(p2_oe),
    .serial_interrupt_in_out(sin), .socket_a_indicator_n_out(ind_a_n),
    .socket_b_indicator_n_out(ind_b_n), .combined_activity_indicator_n_out(ind_c_n)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // detect pulses are single cycles, so tally them on every falling edge
  always @(negedge clk) begin
    if (event_o[0] === 1'b1) begin
      ev_cnt++;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one host cycle; a gap edge follows so strobes never stack
  task automatic acc(input logic w, input logic m, input logic f, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    hr <= '{~w, w, m, f, a, d};
    @(posedge clk);
    hr <= '0;
    @(negedge clk);
  endtask

  task automatic xw(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, 12'h02E, i);
    acc(1'b1, 1'b0, 1'b0, 12'h02F, d);
  endtask

  task automatic xr(input logic [7:0] i, input logic [7:0] e);
    acc(1'b1, 1'b0, 1'b0, 12'h02E, i);
    acc(1'b0, 1'b0, 1'b0, 12'h02F, 8'h00);
    chk(rdata, e);
  endtask

  // registered outputs follow their cause by one edge
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse_pwr();
    @(posedge clk);
    pwr_wr <= 2'b01;
    pwr_vcc <= 2'b01;
    @(posedge clk);
    pwr_wr <= 2'b00;
    @(negedge clk);
  endtask

  task automatic seg_pulse(input logic keep);
    @(posedge clk);
    pme <= keep;
    seg <= 1'b1;
    @(posedge clk);
    seg <= 1'b0;
    @(negedge clk);
  endtask

  task automatic test_reset_values();
    acc(1'b0, 1'b0, 1'b0, 12'h02E, 8'h00);
    chk(rdata, 8'h00);
    xr(8'h03, 8'h00);
    xr(8'h05, 8'h00);
    xr(8'h21, 8'h00);
    chk({6'h00, den}, 8'h00);
  endtask

  // native pin functions outside pci/way mode: interrupt a out, serial line in
  task automatic test_native();
    @(posedge clk);
    irq_n <= 1'b0;
    pin2 <= 1'b0;
    settle();
    chk({6'h00, p1_oe, sin}, 8'h02);
    @(posedge clk);
    irq_n <= 1'b1;
    pin2 <= 1'b1;
    settle();
    chk({6'h00, p1_oe, sin}, 8'h01);
  endtask

  task automatic test_access();
    xw(8'h03, 8'h1A);
    xr(8'h03, 8'h1A);
    acc(1'b1, 1'b1, 1'b0, 12'h841, 8'h5C);
    xr(8'h06, 8'h5C);
    xw(8'h21, 8'hC3);
    acc(1'b0, 1'b1, 1'b0, 12'h846, 8'h00);
    chk(rdata, 8'hC3);
    xw(8'h0A, 8'hFF);
    xr(8'h0A, 8'h00);
    acc(1'b0, 1'b0, 1'b0, 12'h02E, 8'h00);
    chk(rdata, 8'h0A);
    acc(1'b1, 1'b1, 1'b1, 12'h914, 8'h05);
    xr(8'h14, 8'h00);
    xw(8'h03, 8'h00);
  endtask

  task automatic test_power_lock();
    xw(8'h03, 8'h01);
    pulse_pwr();
    chk({6'h00, vcc}, 8'h00);
    xw(8'h03, 8'h00);
    pulse_pwr();
    chk({6'h00, vcc}, 8'h01);
  endtask

  task automatic test_dma_select();
    logic [1:0] want [4];
    want = '{2'b00, 2'b01, 2'b11, 2'b01};
    // inpack idle, wp high, bvd2 low: inpack and bvd2 read low, wp high
    @(posedge clk);
    pins[0].inpack_n <= 1'b1;
    pins[0].wp <= 1'b1;
    pins[0].bvd2 <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      xw(8'h03, {k[1:0], 6'h00});
      settle();
      chk({6'h00, dreq[0], den[0]}, {6'h00, want[k]});
    end
    xw(8'h03, 8'h00);
  endtask

  task automatic test_pullup();
    @(posedge clk);
    pins[0].card_in <= 1'b1;
    settle();
    chk({7'h00, present[0]}, 8'h01);
    // clear the tally off the falling edge so the insertion pulse cannot race it
    @(posedge clk);
    ev_cnt = 0;
    xw(8'h03, 8'h20);
    settle();
    chk(ev_cnt[7:0], 8'h01);
    chk({7'h00, pu_off[0]}, 8'h01);
    @(posedge clk);
    pins[0].card_in <= 1'b0;
    settle();
    chk({7'h00, present[0]}, 8'h01);
    chk(ev_cnt[7:0], 8'h01);
    xw(8'h03, 8'h00);
    settle();
    chk({7'h00, present[0]}, 8'h00);
  endtask

  task automatic test_upper_match();
    // window 1 holds 5C, window 6 holds C3, the rest are zero
    @(posedge clk);
    addr_hi <= 8'h33;
    wtype[0] <= 7'h7F;
    wspace[0] <= 7'h0F;
    settle();
    chk({1'b0, upper_ok[0]}, 8'h0F);
    @(posedge clk);
    wtype[0] <= 7'h00;
    settle();
    chk({1'b0, upper_ok[0]}, 8'h60);
    @(posedge clk);
    addr_hi <= 8'h00;
    settle();
    chk({1'b0, upper_ok[0]}, 8'h7D);
  endtask

  task automatic test_indicator();
    @(posedge clk);
    way <= 1'b1;
    xw(8'h03, 8'h04);
    @(posedge clk);
    pins[0].busy <= 1'b1;
    settle();
    chk({6'h00, ind_a_n, ind_c_n}, 8'h00);
    @(posedge clk);
    pins[0].busy <= 1'b0;
    settle();
    chk({6'h00, ind_a_n, ind_c_n}, 8'h03);
    // socket b enabled through its own index/data pair
    acc(1'b1, 1'b0, 1'b0, 12'h06E, 8'h03);
    acc(1'b1, 1'b0, 1'b0, 12'h06F, 8'h04);
    @(posedge clk);
    pins[1].busy <= 1'b1;
    settle();
    chk({5'h00, ind_a_n, ind_b_n, ind_c_n}, 8'h04);
    @(posedge clk);
    way <= 1'b0;
    pins[0].busy <= 1'b1;
    settle();
    chk({6'h00, ind_a_n, ind_b_n}, 8'h03);
    @(posedge clk);
    pins[0].busy <= 1'b0;
    pins[1].busy <= 1'b0;
  endtask

  task automatic test_pin_mux();
    @(posedge clk);
    g1 <= 1'b1;
    g1_oe <= 1'b1;
    g2 <= 1'b0;
    g2_oe <= 1'b1;
    xw(8'h14, 8'h05);
    settle();
    chk({4'h0, p1_o, p1_oe, p2_o, p2_oe}, 8'h0D);
    xw(8'h03, 8'h0C);
    seg_pulse(1'b1);
    xr(8'h14, 8'h05);
    xr(8'h03, 8'h00);
    seg_pulse(1'b0);
    xr(8'h14, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 12'h914, 8'h01);
    xr(8'h14, 8'h01);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    ev_cnt = 0;
    arst_n = 1'b0;
    seg = 1'b0;
    pme = 1'b0;
    way = 1'b0;
    hr = '0;
    pwr_wr = 2'b00;
    pwr_vcc = 2'b00;
    pins = '0;
    addr_hi = 8'h00;
    wtype = '0;
    wspace = '0;
    g1 = 1'b0;
    g1_oe = 1'b0;
    g2 = 1'b0;
    g2_oe = 1'b0;
    irq_n = 1'b1;
    pin2 = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    test_reset_values();
    test_native();
    test_access();
    test_power_lock();
    test_dma_select();
    test_pullup();
    test_upper_match();
    test_indicator();
    test_pin_mux();
    summarize();
  end
endmodule // extended_register_window_tb
